// [rtl/pmtr_pkg.sv]
// Package for the program memory and table read block
// Contract
// - Program store holds 1024 words of 14 bits, fetched by program counter.
// - After reset the program counter is zero and fetch starts there.
// - Table pointer supplies the low byte of the word address of table reads.
// - Low eight bits of the table word go to the named data register.
// - Upper six bits go to the high latch, unused bits read zero.
// - Current-page read offsets the pointer within the page of the program counter.
// - Last-page read combines the pointer with the page starting at 300H.
// - High latch is read only; software writes have no effect.
// - Every table instruction takes two instruction cycles.
// - A page spans 256 words chosen by program counter bits above the low byte.
package pmtr_pkg;
  localparam int unsigned PMTR_ADDR_W    = 10;
  localparam int unsigned PMTR_WORD_W    = 14;
  localparam int unsigned PMTR_DEPTH     = 1024;
  localparam int unsigned PMTR_BYTE_W    = 8;
  localparam int unsigned PMTR_HIGH_W    = 6;
  localparam int unsigned PMTR_PAGE_W    = 2;
  localparam int unsigned PMTR_DREG_W    = 8;
  localparam logic [9:0]  PMTR_RESET_VEC = 10'h000;
  localparam logic [9:0]  PMTR_LAST_PAGE = 10'h300;

  typedef enum logic [1:0] {
    PMTR_OP_NONE    = 2'b00,
    PMTR_OP_CURPAGE = 2'b01,
    PMTR_OP_LASTPG  = 2'b10
  } pmtr_op_t;

  typedef enum logic [0:0] {
    PMTR_ST_FETCH = 1'b0,
    PMTR_ST_TABLE = 1'b1
  } pmtr_state_t;

  // Result of one table read towards the data memory
  typedef struct packed {
    logic                   valid;
    logic [PMTR_DREG_W-1:0] dest;
    logic [PMTR_BYTE_W-1:0] data;
  } pmtr_dwrite_t;
endpackage : pmtr_pkg

// [rtl/pmtr_store.sv]
// Program word store with one registered read port and a load port
`timescale 1ns/10ps
module pmtr_store
  import pmtr_pkg::*;
(
  // Clock
  input  wire logic                   i_clk_sys,
  // Read port
  input  wire logic                   i_rd_en,
  input  wire logic [PMTR_ADDR_W-1:0] i_rd_addr,
  output logic      [PMTR_WORD_W-1:0] o_rd_data,
  // Load port
  input  wire logic                   i_wr_en,
  input  wire logic [PMTR_ADDR_W-1:0] i_wr_addr,
  input  wire logic [PMTR_WORD_W-1:0] i_wr_data
);
  logic [PMTR_WORD_W-1:0] mem [PMTR_DEPTH];

  // No reset on the array or its read register, so it maps onto block memory
  always_ff @(posedge i_clk_sys) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
    if (i_rd_en) begin
      o_rd_data <= mem[i_rd_addr];
    end
  end
endmodule : pmtr_store

// [rtl/pmtr_top.sv]
// Program counter fetch and table read path
`timescale 1ns/10ps
module pmtr_top
  import pmtr_pkg::*;
(
  // Clock and reset
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_reset_n,
  // Sequencer control, one pulse per instruction cycle
  input  wire logic                   i_cyc_en,
  input  wire logic                   i_jump,
  input  wire logic [PMTR_ADDR_W-1:0] i_jump_addr,
  input  wire pmtr_op_t               i_table_read_op,
  input  wire logic [PMTR_DREG_W-1:0] i_table_dest,
  // Pointer and latch access from the data bus
  input  wire logic [PMTR_BYTE_W-1:0] i_table_ptr,
  input  wire logic                   i_high_wr,
  input  wire logic [PMTR_BYTE_W-1:0] i_high_wdata,
  // Store load port
  input  wire logic                   i_load_en,
  input  wire logic [PMTR_ADDR_W-1:0] i_load_addr,
  input  wire logic [PMTR_WORD_W-1:0] i_load_data,
  // Fetch outputs
  output logic      [PMTR_ADDR_W-1:0] o_pc,
  output logic      [PMTR_WORD_W-1:0] o_instr,
  output logic                        o_instr_valid,
  output logic                        o_stall,
  // Table read outputs
  output pmtr_dwrite_t                o_dwrite,
  output logic      [PMTR_BYTE_W-1:0] o_table_high_latch
);
  pmtr_state_t            state_reg, state_next;
  logic [PMTR_ADDR_W-1:0] pc_reg, pc_next;
  logic [PMTR_HIGH_W-1:0] high_reg, high_next;
  logic [PMTR_DREG_W-1:0] dest_reg, dest_next;
  logic                   fetch_pend_reg, fetch_pend_next;
  logic                   tbl_pend_reg, tbl_pend_next;
  logic                   rd_en;
  logic [PMTR_ADDR_W-1:0] rd_addr;
  logic [PMTR_ADDR_W-1:0] tbl_addr;
  logic [PMTR_WORD_W-1:0] rd_data;
  logic                   tbl_start;

  assign tbl_start = i_cyc_en && (state_reg == PMTR_ST_FETCH)
                     && (i_table_read_op != PMTR_OP_NONE);

  // Table address from pointer and page bits
  always_comb begin
    if (i_table_read_op == PMTR_OP_LASTPG) begin
      tbl_addr = {PMTR_LAST_PAGE[PMTR_ADDR_W-1:PMTR_BYTE_W], i_table_ptr};
    end else begin
      tbl_addr = {pc_reg[PMTR_ADDR_W-1:PMTR_BYTE_W], i_table_ptr};
    end
  end

  // Store port: table word in the cycle the table read issues, else the instruction
  always_comb begin
    // Extra cycle leaves the store idle, so no stray word is read then
    rd_en   = i_cyc_en && (state_reg == PMTR_ST_FETCH);
    rd_addr = pc_reg;
    if (tbl_start) begin
      rd_addr = tbl_addr;
    end
  end

  pmtr_store u_store (
    .i_clk_sys (i_clk_sys),
    .i_rd_en   (rd_en),
    .i_rd_addr (rd_addr),
    .o_rd_data (rd_data),
    .i_wr_en   (i_load_en),
    .i_wr_addr (i_load_addr),
    .i_wr_data (i_load_data)
  );

  // Sequencer next state
  always_comb begin
    state_next      = state_reg;
    pc_next         = pc_reg;
    high_next       = high_reg;
    dest_next       = dest_reg;
    fetch_pend_next = 1'b0;
    tbl_pend_next   = 1'b0;
    if (tbl_pend_reg) begin
      high_next = rd_data[PMTR_WORD_W-1:PMTR_BYTE_W];
    end
    if (i_cyc_en) begin
      case (state_reg)
        PMTR_ST_FETCH: begin
          if (tbl_start) begin
            state_next    = PMTR_ST_TABLE;
            dest_next     = i_table_dest;
            tbl_pend_next = 1'b1;
          end else begin
            fetch_pend_next = 1'b1;
            pc_next = i_jump ? i_jump_addr : pc_reg + 10'h001;
          end
        end
        PMTR_ST_TABLE: begin
          state_next = PMTR_ST_FETCH;
        end
        default: state_next = PMTR_ST_FETCH;
      endcase
    end
  end

  // Latch ignores i_high_wr / i_high_wdata: read only
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg      <= PMTR_ST_FETCH;
      pc_reg         <= PMTR_RESET_VEC;
      high_reg       <= '0;
      dest_reg       <= '0;
      fetch_pend_reg <= 1'b0;
      tbl_pend_reg   <= 1'b0;
    end else begin
      state_reg      <= state_next;
      pc_reg         <= pc_next;
      high_reg       <= high_next;
      dest_reg       <= dest_next;
      fetch_pend_reg <= fetch_pend_next;
      tbl_pend_reg   <= tbl_pend_next;
    end
  end

  assign o_pc               = pc_reg;
  assign o_instr            = fetch_pend_reg ? rd_data : '0;
  assign o_instr_valid      = fetch_pend_reg;
  assign o_stall            = (state_reg == PMTR_ST_TABLE);
  assign o_table_high_latch = {2'b00, high_reg};
  assign o_dwrite.valid     = tbl_pend_reg;
  assign o_dwrite.dest      = dest_reg;
  assign o_dwrite.data      = tbl_pend_reg ? rd_data[PMTR_BYTE_W-1:0] : '0;

  // Checks on fetch, table read and latch behaviour
  sequence seq_fetch_issue;
    i_cyc_en && (state_reg == PMTR_ST_FETCH) && (i_table_read_op == PMTR_OP_NONE);
  endsequence

  sequence seq_tbl_issue;
    tbl_start;
  endsequence

  sequence seq_tbl_done;
    ##1 o_dwrite.valid ##0 o_stall;
  endsequence

  AST_RESET_PC: assert property (@(posedge i_clk_sys)
    $rose(i_reset_n) |-> o_pc == PMTR_RESET_VEC)
    else $error("pc not at reset vector");

  AST_TBL_DONE: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    seq_tbl_issue |-> seq_tbl_done)
    else $error("table read not completed next cycle");

  AST_NO_FETCH: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    o_dwrite.valid |-> !o_instr_valid)
    else $error("instruction fetched during table cycle");

  AST_PC_HOLD: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    tbl_start |=> $stable(o_pc))
    else $error("pc moved during table read");

  AST_LASTPG: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (tbl_start && i_table_read_op == PMTR_OP_LASTPG) |-> rd_addr[9:8] == 2'b11)
    else $error("last page address wrong");

  AST_CURPG: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (tbl_start && i_table_read_op == PMTR_OP_CURPAGE)
      |-> rd_addr == {o_pc[9:8], i_table_ptr})
    else $error("current page address wrong");

  AST_LOW_BYTE: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    seq_tbl_issue |=> o_dwrite.data == $past(u_store.mem[rd_addr][7:0]))
    else $error("low byte mismatch");

  AST_HIGH: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    o_dwrite.valid |=> o_table_high_latch == {2'b00, $past(rd_data[13:8])})
    else $error("high latch not loaded");

  AST_RO: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (i_high_wr && !o_dwrite.valid) |=> $stable(o_table_high_latch))
    else $error("high latch changed by write");

  AST_STALL_ONE: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (o_stall && i_cyc_en) |=> !o_stall)
    else $error("stall longer than one cycle");

  AST_RESET_OUT: assert property (@(posedge i_clk_sys)
    $rose(i_reset_n) |-> !o_instr_valid && !o_dwrite.valid && !o_stall)
    else $error("outputs active right after reset");

  AST_FETCH_WORD: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    seq_fetch_issue |=> o_instr_valid && (o_instr == $past(u_store.mem[o_pc])))
    else $error("fetched word does not match store");

  AST_PC_STEP: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (seq_fetch_issue ##0 !i_jump) |=> o_pc == $past(o_pc) + 10'h001)
    else $error("pc did not step by one");

  AST_PC_JUMP: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (seq_fetch_issue ##0 i_jump) |=> o_pc == $past(i_jump_addr))
    else $error("pc did not take jump target");

  AST_IDLE_HOLD: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    !i_cyc_en |=> $stable(o_pc) && !o_instr_valid && !o_dwrite.valid)
    else $error("activity without a cycle strobe");

  AST_DEST: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    seq_tbl_issue |=> o_dwrite.dest == $past(i_table_dest))
    else $error("table destination mismatch");

  AST_STORE_QUIET: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    o_stall |-> !rd_en)
    else $error("store read during table cycle");

  AST_JUMP_REFUSED: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (o_stall && i_cyc_en) |=> $stable(o_pc) && !o_instr_valid && !o_dwrite.valid)
    else $error("strobe in table cycle was acted on");

  AST_INSTR_ZERO: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    !o_instr_valid |-> o_instr == 14'h0000)
    else $error("instruction word not zero while idle");

  // Latch may only move on the edge after a table result
  AST_HIGH_KEEP: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    !o_dwrite.valid |=> $stable(o_table_high_latch))
    else $error("high latch changed outside a table read");
endmodule : pmtr_top

// [bench/pmtr_seq_model.sv]
// Instruction sequencer model that issues cycle strobes to the fetch block
`timescale 1ns/10ps
module pmtr_seq_model
  import pmtr_pkg::*;
(
  // Clock
  input  wire logic                   i_clk_sys,
  // Sequencer control
  output logic                        o_cyc_en,
  output logic                        o_jump,
  output logic      [PMTR_ADDR_W-1:0] o_jump_addr,
  output pmtr_op_t                    o_op,
  output logic      [PMTR_DREG_W-1:0] o_dest,
  output logic      [PMTR_BYTE_W-1:0] o_ptr
);
  initial begin
    o_cyc_en = 1'b0;
    o_jump = 1'b0;
    o_jump_addr = 10'h000;
    o_op = PMTR_OP_NONE;
    o_dest = 8'h00;
    o_ptr = 8'h00;
  end

  // One strobe per call, so strobes are never closer than two clocks
  task automatic issue(input pmtr_op_t op, input logic [7:0] ptr, input logic [7:0] dest,
                       input logic jump, input logic [9:0] jaddr);
    @(posedge i_clk_sys);
    #10;
    o_cyc_en = 1'b1;
    o_jump = jump;
    o_jump_addr = jaddr;
    o_op = op;
    o_dest = dest;
    o_ptr = ptr;
    @(posedge i_clk_sys);
    #10;
    o_cyc_en = 1'b0;
    o_jump = 1'b0;
    o_op = PMTR_OP_NONE;
    // Target is stale once the strobe is gone
    o_jump_addr = ~jaddr;
  endtask : issue
endmodule : pmtr_seq_model

// [bench/tb_pmtr_top.sv]
// Self-checking bench for the program fetch and table read block
`timescale 1ns/10ps
module tb_pmtr_top;
  import pmtr_pkg::*;
  logic         i_clk_sys = 1'b0;
  logic         i_reset_n, cyc, jmp, hwr, lden, ival, stall;
  logic [9:0]   ja, ldad, pc, epc, a;
  pmtr_op_t     op;
  logic [7:0]   dst, ptr, hwd, hl, ehl;
  logic [13:0]  ldd, instr;
  logic [13:0]  mem [1024];
  pmtr_dwrite_t dw;
  logic [21:0]  iq[$], dq[$];
  int           fail_count = 0;
  int           checked = 0;

  always #50 i_clk_sys = ~i_clk_sys;

  pmtr_seq_model pmtr_seq_model_i (.i_clk_sys(i_clk_sys), .o_cyc_en(cyc), .o_jump(jmp),
    .o_jump_addr(ja), .o_op(op), .o_dest(dst), .o_ptr(ptr));

  pmtr_top pmtr_top_i (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_cyc_en(cyc),
    .i_jump(jmp), .i_jump_addr(ja), .i_table_read_op(op), .i_table_dest(dst),
    .i_table_ptr(ptr), .i_high_wr(hwr), .i_high_wdata(hwd), .i_load_en(lden),
    .i_load_addr(ldad), .i_load_data(ldd), .o_pc(pc), .o_instr(instr),
    .o_instr_valid(ival), .o_stall(stall), .o_dwrite(dw), .o_table_high_latch(hl));

  task automatic chk(input logic [21:0] seen, input logic [21:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim

  task automatic fetch(input logic j, input logic [9:0] t);
    iq.push_back({8'h00, mem[epc]});
    pmtr_seq_model_i.issue(PMTR_OP_NONE, 8'($urandom), 8'($urandom), j, t);
    epc = j ? t : epc + 10'h001;
    chk({12'h000, pc}, {12'h000, epc});
  endtask : fetch

  // Results leave in issue order, so the oldest note matches
  always @(negedge i_clk_sys) begin
    if (ival === 1'b1)
      chk({8'h00, instr}, (iq.size() > 0) ? iq.pop_front() : 22'h3FFFFF);
    else
      chk({8'h00, instr}, 22'h000000);
    if (dw.valid === 1'b1)
      chk({6'h00, dw.dest, dw.data}, (dq.size() > 0) ? dq.pop_front() : 22'h3FFFFF);
  end

  initial begin
    repeat (60000) @(posedge i_clk_sys);
    fail_count++;
    end_sim();
  end

  initial begin
    i_reset_n = 1'b0;
    {hwr, hwd, lden, ldad, ldd} = '0;
    void'($urandom(32'h79DB7E67));
    repeat (3) @(posedge i_clk_sys);
    #10 i_reset_n = 1'b1;
    chk({12'h000, pc}, 22'h000000);
    for (int k = 0; k < 1024; k++) begin
      @(posedge i_clk_sys);
      #10;
      lden = 1'b1;
      ldad = k[9:0];
      ldd = 14'($urandom);
      mem[k] = ldd;
    end
    @(posedge i_clk_sys);
    #10 lden = 1'b0;
    epc = PMTR_RESET_VEC;
    repeat (3) fetch(1'b0, 10'h000);
    for (int n = 0; n < 16; n++) begin
      fetch(1'b1, 10'($urandom));
      a[7:0] = (n < 2) ? 8'hFF : 8'($urandom);
      a[9:8] = n[0] ? PMTR_LAST_PAGE[9:8] : epc[9:8];
      dq.push_back({6'h00, 8'(n * 17), mem[a][7:0]});
      ehl = {2'b00, mem[a][13:8]};
      pmtr_seq_model_i.issue(n[0] ? PMTR_OP_LASTPG : PMTR_OP_CURPAGE, a[7:0], 8'(n * 17),
                             1'b0, 10'h000);
      chk({21'h0, stall}, 22'h000001);
      hwr = 1'b1;
      hwd = ~ehl;
      @(posedge i_clk_sys);
      #10 chk({14'h0, hl}, {14'h0, ehl});
      // Strobe during the extra cycle must not fetch, jump or start a read
      // Latch write stays up here, outside the result cycle
      pmtr_seq_model_i.issue(PMTR_OP_CURPAGE, 8'($urandom), 8'hAA, 1'b1, 10'($urandom));
      hwr = 1'b0;
      chk({11'h0, stall, pc}, {12'h000, epc});
      chk({14'h0, hl}, {14'h0, ehl});
      fetch(1'b0, 10'h000);
    end
    // Reset again in mid-run; the store keeps its contents
    @(posedge i_clk_sys);
    #10 i_reset_n = 1'b0;
    @(posedge i_clk_sys);
    #10 chk({9'h000, ival, stall, dw.valid, pc}, 22'h000000);
    chk({14'h0, hl}, 22'h000000);
    i_reset_n = 1'b1;
    epc = PMTR_RESET_VEC;
    repeat (2) fetch(1'b0, 10'h000);
    repeat (3) @(posedge i_clk_sys);
    chk(22'(iq.size() + dq.size()), 22'h000000);
    end_sim();
  end
endmodule : tb_pmtr_top
